// file: rtl/sarp_consts.vh
/*
  Shared constants of the sampling converter readout port: widths,
  mode codes, pin positions, output-enable masks and reset values.
  Assumes it is included by bare name from files under rtl/.
*/
`ifndef SARP_CONSTS_VH
`define SARP_CONSTS_VH

// Channels and result words
`define SARP_CH_NUM 8
`define SARP_CH_W 3
`define SARP_GRP_W 2
`define SARP_RES_W 14
`define SARP_RES_MSB 4'hd
`define SARP_ALL_RES_W 112
`define SARP_IDX_W 4
`define SARP_IDX_ZERO 4'h0
`define SARP_IDX_ONE 4'h1
`define SARP_CH_ZERO 3'h0
`define SARP_CH_ONE 3'h1
`define SARP_BIT_ZERO 4'h0
`define SARP_BIT_ONE 4'h1
`define SARP_RES_ZERO 14'h0000

// Data bus layout
`define SARP_BUS_W 16
`define SARP_BYTE_W 8
`define SARP_PAD 2'h0
`define SARP_BYTE_ZERO 8'h00
`define SARP_BUS_ZERO 16'h0000
`define SARP_TOP_PIN 15
`define SARP_ORDER_PIN 14
`define SARP_SER_A_PIN 7
`define SARP_SER_B_PIN 8

// Output-enable masks per mode
`define SARP_OE_NONE 16'h0000
`define SARP_OE_PAR 16'hffff
`define SARP_OE_BYTE 16'h00ff
`define SARP_OE_SER 16'h0180

// Readout modes
`define SARP_MODE_W 2
`define SARP_MODE_PAR 2'h0
`define SARP_MODE_BYTE 2'h1
`define SARP_MODE_SER 2'h2

// Oversampling select and decoded ratio
`define SARP_OS_W 3
`define SARP_OS_BAD 3'h7
`define SARP_OSR_W 7
`define SARP_OSR_ONE 7'h01

`endif

// file: rtl/sarp_sync.v
/*
  Two-flop synchroniser of parameterised width for pin inputs.
  Assumes the inputs are quasi-static or slow against mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sarp_sync #(
  parameter W = 1
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta;
  reg [W-1:0] stable;

  // First stage is read only by the second stage
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      stable <= {W{1'b0}};
    end else begin
      meta <= d_i;
      stable <= meta;
    end
  end

  assign q_o = stable;

endmodule // sarp_sync

`default_nettype wire

// file: rtl/sarp_result_mem.v
/*
  Result store of eight 14-bit conversion words, written all at once
  and read through two registered ports.
  Assumes the write strobe comes from logic on mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sarp_consts.vh"

module sarp_result_mem (
  input wire mclk_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [`SARP_ALL_RES_W-1:0] wr_data_i,
  input wire [`SARP_CH_W-1:0] rd_addr_a_i,
  input wire [`SARP_CH_W-1:0] rd_addr_b_i,
  output reg [`SARP_RES_W-1:0] rd_data_a_o,
  output reg [`SARP_RES_W-1:0] rd_data_b_o
);

  reg [`SARP_RES_W-1:0] store [0:`SARP_CH_NUM-1];
  integer i;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < `SARP_CH_NUM; i = i + 1) begin
        store[i] <= `SARP_RES_ZERO;
      end
      rd_data_a_o <= `SARP_RES_ZERO;
      rd_data_b_o <= `SARP_RES_ZERO;
    end else begin
      if (wr_en_i) begin
        for (i = 0; i < `SARP_CH_NUM; i = i + 1) begin
          store[i] <= wr_data_i[i*`SARP_RES_W +: `SARP_RES_W];
        end
      end
      rd_data_a_o <= store[rd_addr_a_i];
      rd_data_b_o <= store[rd_addr_b_i];
    end
  end

endmodule // sarp_result_mem

`default_nettype wire

// file: rtl/sarp_readout_port.v
/*
  Conversion status and result readout port of an eight-channel
  14-bit simultaneous-sampling converter: start capture, busy flag,
  first-channel flag and 16-bit, byte-wide and dual-line serial readout.
  Assumes a conversion core on mclk_i that takes a start pulse and
  returns a done pulse with all eight results; all host pins are
  asynchronous and pass two flops before use.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sarp_consts.vh"

// Notes on behaviour
// - Oversample select pins decode binary, pin2 MSB
// - Busy rises after both start rising edges
// - Start edges ignored while busy
// - Busy falls once all results latched
// - Flag tri-state until chip select falls
// - Parallel: flag high for channel one only
// - Byte: flag high for both channel-one bytes
// - Serial: flag high until fourteenth clock fall
// - Select high: top pin picks serial/byte
// - Parallel: result MSB on pin 15, next 14
// - Parallel: bits 6,5 on pins 8,7
// - Parallel: bits 4..0 on 6..2, 1..0 low
// - Byte: order pin high sends upper first
// - Byte: padded word over two strobes, pins 7..0
// - Byte: pin 8 always tri-state
// - Serial: channels 1-4 line A, 5-8 line B
// - Select low picks 16-bit parallel
// - Chip select rise tri-states bus and flag; busy stays driven
// - Serial clock on read pin, rising-timed
module sarp_readout_port (
  input wire mclk_i,
  input wire rst_i,
  input wire convert_start_a_i,
  input wire convert_start_b_i,
  input wire cs_n_i,
  input wire rd_sclk_i,
  input wire interface_select_i,
  input wire [`SARP_OS_W-1:0] oversample_ratio_sel_i,
  input wire [`SARP_BUS_W-1:0] parallel_data_bus_i,
  output reg [`SARP_BUS_W-1:0] parallel_data_bus_o,
  output reg [`SARP_BUS_W-1:0] parallel_data_bus_oe_o,
  output reg first_channel_flag_o,
  output reg first_channel_flag_oe_o,
  output reg busy_o,
  output reg [`SARP_OSR_W-1:0] oversample_ratio_o,
  output reg core_start_o,
  input wire core_done_i,
  input wire [`SARP_ALL_RES_W-1:0] core_result_i
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ARM = 2'h1;
  localparam ST_CONV = 2'h2;

  // Synchronised pin levels
  wire start_a_s;
  wire start_b_s;
  wire cs_n_s;
  wire rd_s;
  wire sel_s;
  wire [1:0] ctl_s;
  wire [`SARP_OS_W-1:0] os_s;

  reg start_a_q;
  reg start_b_q;
  reg cs_n_q;
  reg rd_q;

  reg [1:0] state;
  reg [1:0] next_state;
  reg seen_a;
  reg seen_b;
  reg next_seen_a;
  reg next_seen_b;
  reg next_busy;
  reg next_core_start;
  reg mem_wr;

  reg [`SARP_MODE_W-1:0] mode;
  reg [`SARP_IDX_W-1:0] rd_cnt;
  reg [`SARP_IDX_W-1:0] pres_idx;
  reg pres_valid;
  reg [`SARP_IDX_W-1:0] bit_cnt;
  reg [`SARP_CH_W-1:0] ser_ch;

  reg [`SARP_CH_W-1:0] addr_a;
  wire [`SARP_CH_W-1:0] addr_b;
  wire [`SARP_RES_W-1:0] word_a;
  wire [`SARP_RES_W-1:0] word_b;
  wire [`SARP_BUS_W-1:0] padded_a;
  wire [`SARP_IDX_W-1:0] bit_pos;

  reg [`SARP_BUS_W-1:0] next_bus;
  reg [`SARP_BUS_W-1:0] next_oe;
  reg next_flag;
  reg [`SARP_OSR_W-1:0] next_osr;

  wire start_a_rise;
  wire start_b_rise;
  wire cs_fall;
  wire cs_low;
  wire rd_low;
  wire rd_fall;
  wire upper_first;
  wire upper_sel;

  sarp_sync #(.W(1)) u_sync_start_a (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(convert_start_a_i),
    .q_o(start_a_s)
  );

  sarp_sync #(.W(1)) u_sync_start_b (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(convert_start_b_i),
    .q_o(start_b_s)
  );

  // Chip select resets high so nothing drives before the host
  sarp_sync #(.W(1)) u_sync_cs (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(~cs_n_i),
    .q_o(cs_low)
  );

  sarp_sync #(.W(1)) u_sync_rd (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(rd_sclk_i),
    .q_o(rd_s)
  );

  sarp_sync #(.W(1)) u_sync_sel (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(interface_select_i),
    .q_o(sel_s)
  );

  sarp_sync #(.W(2)) u_sync_ctl (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i({parallel_data_bus_i[`SARP_TOP_PIN], parallel_data_bus_i[`SARP_ORDER_PIN]}),
    .q_o(ctl_s)
  );

  sarp_sync #(.W(`SARP_OS_W)) u_sync_os (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(oversample_ratio_sel_i),
    .q_o(os_s)
  );

  sarp_result_mem u_mem (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_en_i(mem_wr),
    .wr_data_i(core_result_i),
    .rd_addr_a_i(addr_a),
    .rd_addr_b_i(addr_b),
    .rd_data_a_o(word_a),
    .rd_data_b_o(word_b)
  );

  assign cs_n_s = ~cs_low;
  assign start_a_rise = start_a_s & ~start_a_q;
  assign start_b_rise = start_b_s & ~start_b_q;
  assign cs_fall = cs_n_q & ~cs_n_s;
  assign rd_low = ~rd_s;
  assign rd_fall = rd_q & ~rd_s;
  assign upper_first = ctl_s[0];
  assign upper_sel = upper_first ^ pres_idx[0];
  assign padded_a = {word_a, `SARP_PAD};
  assign bit_pos = `SARP_RES_MSB - bit_cnt;
  assign addr_b = {1'b1, ser_ch[`SARP_GRP_W-1:0]};

  // Conversion control
  always @* begin
    next_state = state;
    next_seen_a = seen_a;
    next_seen_b = seen_b;
    next_busy = busy_o;
    next_core_start = 1'b0;
    mem_wr = 1'b0;
    case (state)
      ST_IDLE, ST_ARM: begin
        next_seen_a = seen_a | start_a_rise;
        next_seen_b = seen_b | start_b_rise;
        if (next_seen_a & next_seen_b) begin
          next_state = ST_CONV;
          next_busy = 1'b1;
          next_core_start = 1'b1;
          next_seen_a = 1'b0;
          next_seen_b = 1'b0;
        end else if (next_seen_a | next_seen_b) begin
          next_state = ST_ARM;
        end
      end
      ST_CONV: begin
        // Start edges are not looked at here
        if (core_done_i) begin
          mem_wr = 1'b1;
          next_busy = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_seen_a = 1'b0;
        next_seen_b = 1'b0;
        next_busy = 1'b0;
      end
    endcase
  end

  // Memory address follows the word being presented
  always @* begin
    case (mode)
      `SARP_MODE_SER: addr_a = {1'b0, ser_ch[`SARP_GRP_W-1:0]};
      `SARP_MODE_BYTE: addr_a = pres_idx[`SARP_IDX_W-1:1];
      default: addr_a = pres_idx[`SARP_CH_W-1:0];
    endcase
  end

  // Pin values for the next cycle
  always @* begin
    next_bus = `SARP_BUS_ZERO;
    next_oe = `SARP_OE_NONE;
    next_flag = 1'b0;
    case (mode)
      `SARP_MODE_PAR: begin
        next_bus = padded_a;
        if (cs_low & rd_low) begin
          next_oe = `SARP_OE_PAR;
        end
        next_flag = pres_valid & (pres_idx[`SARP_CH_W-1:0] == `SARP_CH_ZERO);
      end
      `SARP_MODE_BYTE: begin
        if (upper_sel) begin
          next_bus = {`SARP_BYTE_ZERO, padded_a[`SARP_BUS_W-1:`SARP_BYTE_W]};
        end else begin
          next_bus = {`SARP_BYTE_ZERO, padded_a[`SARP_BYTE_W-1:0]};
        end
        // Pin 8 and the upper pins stay released
        if (cs_low & rd_low) begin
          next_oe = `SARP_OE_BYTE;
        end
        next_flag = pres_valid & (pres_idx[`SARP_IDX_W-1:1] == `SARP_CH_ZERO);
      end
      `SARP_MODE_SER: begin
        next_bus[`SARP_SER_A_PIN] = word_a[bit_pos];
        next_bus[`SARP_SER_B_PIN] = word_b[bit_pos];
        if (cs_low) begin
          next_oe = `SARP_OE_SER;
        end
        next_flag = (ser_ch == `SARP_CH_ZERO);
      end
      default: begin
        next_bus = `SARP_BUS_ZERO;
      end
    endcase
    if (!cs_low) begin
      next_flag = 1'b0;
    end
  end

  // Oversampling ratio decode; the unused code falls back to no filtering
  always @* begin
    if (os_s == `SARP_OS_BAD) begin
      next_osr = `SARP_OSR_ONE;
    end else begin
      next_osr = `SARP_OSR_ONE << os_s;
    end
  end

  // Edge history, conversion state and mode
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start_a_q <= 1'b0;
      start_b_q <= 1'b0;
      cs_n_q <= 1'b1;
      rd_q <= 1'b0;
      state <= ST_IDLE;
      seen_a <= 1'b0;
      seen_b <= 1'b0;
      busy_o <= 1'b0;
      core_start_o <= 1'b0;
      mode <= `SARP_MODE_PAR;
      oversample_ratio_o <= `SARP_OSR_ONE;
    end else begin
      start_a_q <= start_a_s;
      start_b_q <= start_b_s;
      cs_n_q <= cs_n_s;
      rd_q <= rd_s;
      state <= next_state;
      seen_a <= next_seen_a;
      seen_b <= next_seen_b;
      busy_o <= next_busy;
      core_start_o <= next_core_start;
      oversample_ratio_o <= next_osr;
      if (!sel_s) begin
        mode <= `SARP_MODE_PAR;
      end else if (ctl_s[1]) begin
        mode <= `SARP_MODE_BYTE;
      end else begin
        mode <= `SARP_MODE_SER;
      end
    end
  end

  // Readout counters; held at the frame start while chip select is high
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_cnt <= `SARP_IDX_ZERO;
      pres_idx <= `SARP_IDX_ZERO;
      pres_valid <= 1'b0;
      bit_cnt <= `SARP_BIT_ZERO;
      ser_ch <= `SARP_CH_ZERO;
    end else if (!cs_low) begin
      rd_cnt <= `SARP_IDX_ZERO;
      pres_idx <= `SARP_IDX_ZERO;
      pres_valid <= 1'b0;
      bit_cnt <= `SARP_BIT_ZERO;
      ser_ch <= `SARP_CH_ZERO;
    end else if (mode == `SARP_MODE_SER) begin
      // Bits move on the falling clock so the host sees them stable
      // at the rising one
      if (rd_fall & !cs_fall) begin
        if (bit_cnt == `SARP_RES_MSB) begin
          bit_cnt <= `SARP_BIT_ZERO;
          ser_ch <= ser_ch + `SARP_CH_ONE;
        end else begin
          bit_cnt <= bit_cnt + `SARP_BIT_ONE;
        end
      end
    end else if (rd_fall) begin
      // Strobe tied to chip select counts from the same edge
      pres_idx <= rd_cnt;
      rd_cnt <= rd_cnt + `SARP_IDX_ONE;
      pres_valid <= 1'b1;
    end
  end

  // Pin registers
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      parallel_data_bus_o <= `SARP_BUS_ZERO;
      parallel_data_bus_oe_o <= `SARP_OE_NONE;
      first_channel_flag_o <= 1'b0;
      first_channel_flag_oe_o <= 1'b0;
    end else begin
      parallel_data_bus_o <= next_bus;
      parallel_data_bus_oe_o <= next_oe;
      first_channel_flag_o <= next_flag;
      first_channel_flag_oe_o <= cs_low;
    end
  end

endmodule // sarp_readout_port

`default_nettype wire

// file: bench/sarp_chk.sv
/*
  Port checker for the readout port: busy, start, decode and drive masks.
  Assumes it is bound onto sarp_readout_port and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module sarp_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic [2:0] oversample_ratio_sel_i,
  input wire logic [15:0] parallel_data_bus_o,
  input wire logic [15:0] parallel_data_bus_oe_o,
  input wire logic first_channel_flag_oe_o,
  input wire logic busy_o,
  input wire logic [6:0] oversample_ratio_o,
  input wire logic core_start_o,
  input wire logic core_done_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  busy_start_a: assert property ($rose(busy_o) |-> core_start_o)
    else $error("busy rose without a core start");
  start_once_a: assert property (core_start_o |=> !core_start_o && busy_o)
    else $error("core start longer than one cycle");
  no_restart_a: assert property (busy_o && $past(busy_o) |-> !core_start_o)
    else $error("new start while busy");
  busy_end_a: assert property (core_done_i |=> !busy_o)
    else $error("busy held after results latched");
  busy_hold_a: assert property (busy_o && !core_done_i |=> busy_o)
    else $error("busy fell before results latched");
  os_decode_a: assert property ($stable(oversample_ratio_sel_i) [*5] |->
    oversample_ratio_o == ((oversample_ratio_sel_i == 3'h7) ? 7'h01 :
    7'h01 << oversample_ratio_sel_i))
    else $error("oversampling ratio decode wrong");
  oe_mask_a: assert property (parallel_data_bus_oe_o inside
    {16'h0000, 16'hffff, 16'h00ff, 16'h0180})
    else $error("illegal drive mask");
  par_pad_a: assert property (parallel_data_bus_oe_o == 16'hffff |->
    parallel_data_bus_o[1:0] == 2'h0)
    else $error("low pad pins not low");
  cs_off_a: assert property (cs_n_i [*4] |->
    parallel_data_bus_oe_o == 16'h0000 && !first_channel_flag_oe_o)
    else $error("outputs driven with chip select high");
endmodule // sarp_chk

bind sarp_readout_port sarp_chk u_chk (.mclk_i, .rst_i, .cs_n_i, .oversample_ratio_sel_i,
  .parallel_data_bus_o, .parallel_data_bus_oe_o, .first_channel_flag_oe_o, .busy_o,
  .oversample_ratio_o, .core_start_o, .core_done_i);

`default_nettype wire

// file: bench/sarp_host_model.sv
/*
  Host controller model: start pins, chip select, read strobe or serial clock.
  Assumes bus_i carries the resolved pin levels of the shared data bus.
*/
`timescale 1ns/1ps
`default_nettype none

module sarp_host_model (
  input wire logic mclk_i,
  input wire logic [15:0] bus_i,
  input wire logic flag_i,
  output var logic conv_a_o,
  output var logic conv_b_o,
  output var logic cs_n_o,
  output var logic rd_sclk_o
);
  initial begin
    conv_a_o = 1'b0;
    conv_b_o = 1'b0;
    cs_n_o = 1'b1;
    rd_sclk_o = 1'b1;
  end

  task automatic starts(input logic a, input logic b);
    @(posedge mclk_i);
    #2 conv_a_o = a;
    conv_b_o = b;
  endtask

  // Clock stands still high outside frames
  task automatic frame(input logic on);
    @(posedge mclk_i);
    #2 cs_n_o = ~on;
    repeat (8) @(posedge mclk_i);
  endtask

  // Serial bits taken late in the high half, after the rising edge
  task automatic strobe(input int lo, input int hi, input bit late,
    output logic [15:0] w, output logic f);
    @(posedge mclk_i);
    #2 rd_sclk_o = 1'b0;
    repeat (lo) @(posedge mclk_i);
    #2 if (!late) begin
      w = bus_i;
      f = flag_i;
    end
    rd_sclk_o = 1'b1;
    repeat (hi) @(posedge mclk_i);
    #2 if (late) begin
      w = bus_i;
      f = flag_i;
    end
  endtask
endmodule // sarp_host_model

`default_nettype wire

// file: bench/testbench.sv
/*
  Self-checking bench: host model, conversion core stub and checks per mode.
  Assumes rtl/ is on the include path and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk_i, rst_i, sel, pin15, pin14, done, flag, flag_oe, busy, cstart, f;
  logic conv_a, conv_b, cs_n, rd;
  logic [2:0] os;
  logic [6:0] ratio;
  logic [13:0] a, b;
  logic [15:0] dout, oe, lvl, w, wd;
  logic [111:0] res;
  integer seed, mismatches, total_checks, cycles, i, k;

  // Host keeps unused pins low
  assign lvl = (oe & dout) | (~oe & {pin15, pin14, 14'h0000});

  sarp_readout_port u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .convert_start_a_i(conv_a),
    .convert_start_b_i(conv_b), .cs_n_i(cs_n), .rd_sclk_i(rd), .interface_select_i(sel),
    .oversample_ratio_sel_i(os), .parallel_data_bus_i(lvl), .parallel_data_bus_o(dout),
    .parallel_data_bus_oe_o(oe), .first_channel_flag_o(flag),
    .first_channel_flag_oe_o(flag_oe), .busy_o(busy), .oversample_ratio_o(ratio),
    .core_start_o(cstart), .core_done_i(done), .core_result_i(res));

  sarp_host_model u_host (.mclk_i(mclk_i), .bus_i(lvl), .flag_i(flag), .conv_a_o(conv_a),
    .conv_b_o(conv_b), .cs_n_o(cs_n), .rd_sclk_o(rd));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Core stub: fresh random results a fixed time after each start
  always @(posedge mclk_i) begin
    if (cstart === 1'b1) begin
      repeat (20) @(posedge mclk_i);
      #2 res = rand_res();
      done = 1'b1;
      @(posedge mclk_i);
      #2 done = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end

  function automatic [13:0] r(input integer ch);
    r = res[14*ch +: 14];
  endfunction

  // Four draws give 128 bits; only eight 14-bit results are kept
  function automatic [111:0] rand_res();
    logic [127:0] t;
    t = {$random(seed), $random(seed), $random(seed), $random(seed)};
    return t[111:0];
  endfunction

  // Upper pins and pin 8 stay released through byte frames
  always @(posedge mclk_i) begin
    if (sel === 1'b1 && pin15 === 1'b1 && cs_n === 1'b0)
      chk(oe[15:8], 8'h00);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_busy(input logic v);
    int n;
    for (n = 0; n < 200 && busy !== v; n++) begin
      @(posedge mclk_i);
      #1;
    end
    chk(busy, v);
  endtask

  task automatic set_mode(input logic s, input logic p15, input logic p14);
    @(posedge mclk_i);
    #2 sel = s;
    pin15 = p15;
    pin14 = p14;
  endtask

  // Reads only start once busy has fallen
  task automatic convert;
    int gap;
    gap = 1 + {$random(seed)} % 12;
    u_host.starts(1'b1, 1'b0);
    repeat (gap + 6) @(posedge mclk_i);
    #1 chk(busy, 1'b0);
    u_host.starts(1'b1, 1'b1);
    wait_busy(1'b1);
    u_host.starts(1'b0, 1'b0);
    u_host.starts(1'b1, 1'b1);
    wait_busy(1'b0);
    u_host.starts(1'b0, 1'b0);
    repeat (12) @(posedge mclk_i);
    #1 chk(busy, 1'b0);
  endtask

  initial begin
    seed = 62;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    rst_i = 1'b1;
    {sel, pin15, pin14, done, os} = '0;
    res = rand_res();
    repeat (3) @(posedge mclk_i);
    #2 rst_i = 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      #2 os = i[2:0];
      repeat (6) @(posedge mclk_i);
      #1 chk(ratio, (os == 3'h7) ? 7'h01 : 7'h01 << os);
    end
    set_mode(1'b0, 1'b0, 1'b0);
    convert;
    chk(flag_oe, 1'b0);
    u_host.frame(1'b1);
    chk(flag_oe, 1'b1);
    for (i = 0; i < 8; i++) begin
      u_host.strobe(8, 8, 1'b0, w, f);
      chk(w, {r(i), 2'b00});
      chk(f, i == 0);
    end
    u_host.frame(1'b0);
    chk({flag_oe, oe}, 17'h00000);
    for (k = 0; k < 2; k++) begin
      set_mode(1'b1, 1'b1, k[0]);
      convert;
      u_host.frame(1'b1);
      for (i = 0; i < 16; i++) begin
        u_host.strobe(8, 8, 1'b0, w, f);
        wd = {r((i / 2) % 8), 2'b00};
        chk(w[7:0], (((i % 2) == 0) == k) ? wd[15:8] : wd[7:0]);
        chk(f, i < 2);
      end
      u_host.frame(1'b0);
    end
    set_mode(1'b1, 1'b0, 1'b0);
    convert;
    u_host.frame(1'b1);
    for (i = 0; i < 56; i++) begin
      if (i > 0)
        u_host.strobe(4, 3, 1'b1, w, f);
      else begin
        w = lvl;
        f = flag;
      end
      a = r(i / 14);
      b = r(i / 14 + 4);
      chk({w[8], w[7]}, {b[13 - i % 14], a[13 - i % 14]});
      chk(f, i < 14);
    end
    u_host.frame(1'b0);
    finish_test;
  end
endmodule // testbench

`default_nettype wire
